//--- verilog/sfw_core.sv
`default_nettype none
module sfw_core #(
  parameter int SCK_HALF = sfw_pkg::SCK_HALF_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  input  wire logic        fs_i,
  output logic             fs_o,
  output logic             fs_oe_o
);
  if (SCK_HALF < 1 || SCK_HALF > 256) begin : g_chk
    $error("SCK_HALF must lie in 1..256");
  end

  typedef struct packed {
    logic [15:0]       ctl_lo;
    logic [15:0]       ctl_hi;
    logic [4:0]        wlen;
    logic [15:0]       urd_pat;
    logic [15:0]       stage_hi;
    logic [31:0][31:0] tx_mem;
    logic [31:0][31:0] rx_mem;
    logic [4:0]        tx_rp;
    logic [4:0]        tx_wp;
    logic [4:0]        rx_rp;
    logic [4:0]        rx_wp;
    logic [5:0]        tx_cnt;
    logic [5:0]        rx_cnt;
    logic [31:0]       tx_sh;
    logic [31:0]       rx_sh;
    logic [31:0]       last_tx;
    logic [31:0]       last_rx;
    logic              sh_full;
    logic              in_word;
    logic              tail;
    logic [5:0]        bit_cnt;
    logic [5:0]        word_idx;
    logic [7:0]        div;
    logic              sck;
    logic [1:0]        sck_sync;
    logic [1:0]        sdi_sync;
    logic [1:0]        fs_sync;
    logic              sck_prev;
    logic              fs_prev;
    logic              frm_err;
    logic              ovf;
    logic              udr;
    logic [15:0]       rdata;
  } sfw_state_t;

  sfw_state_t s;
  sfw_state_t n;

  function automatic logic [5:0] word_len(input logic aud, input logic m32,
                                          input logic m16,
                                          input logic [4:0] wl);
    if (aud) begin
      word_len = m32 ? (m16 ? sfw_pkg::LEN_24 : sfw_pkg::LEN_32)
                     : sfw_pkg::LEN_16;
    end else if (wl != 5'h00) begin
      word_len = {1'b0, wl} + 6'h01;
    end else begin
      word_len = m32 ? sfw_pkg::LEN_32
               : (m16 ? sfw_pkg::LEN_16 : sfw_pkg::LEN_8);
    end
  endfunction

  function automatic logic [5:0] fifo_depth(input logic m32, input logic m16);
    fifo_depth = m32 ? sfw_pkg::DEPTH_W32
               : (m16 ? sfw_pkg::DEPTH_W16 : sfw_pkg::DEPTH_W8);
  endfunction

  function automatic logic [4:0] frame_mask(input logic [2:0] code);
    case (code)
      3'h0:    frame_mask = 5'h00;
      3'h1:    frame_mask = 5'h01;
      3'h2:    frame_mask = 5'h03;
      3'h3:    frame_mask = 5'h07;
      3'h4:    frame_mask = 5'h0F;
      default: frame_mask = 5'h1F;
    endcase
  endfunction

  logic        on;
  logic        master;
  logic        aud;
  logic        ign;
  logic        framed;
  logic        sync_in;
  logic        pol;
  logic        pulse_word;
  logic [2:0]  fcnt;
  logic [4:0]  fmask;
  logic [5:0]  len;
  logic [5:0]  cap;
  logic [31:0] len_mask;
  logic [31:0] rx_word;
  logic        fs_edge;
  logic        rise;
  logic        fall;
  logic        div_hit;
  logic        repeat_word;
  logic        data_avail;
  logic        halted;
  logic        first_trig;
  logic        start;
  logic        go;
  logic        tx_push;
  logic        tx_pop;
  logic        rx_push;
  logic        rx_pop;
  logic        shifter_idle;
  logic        fs_assert;
  logic [15:0] stat_lo;

  always_comb begin
    n = s;
    n.rdata = 16'h0000;
    rx_word = 32'h00000000;
    n.sck_sync = {s.sck_sync[0], sck_i};
    n.sdi_sync = {s.sdi_sync[0], sdi_i};
    n.fs_sync = {s.fs_sync[0], fs_i};
    n.sck_prev = s.sck_sync[1];
    n.fs_prev = s.fs_sync[1];

    on = s.ctl_lo[sfw_pkg::CL_ON];
    master = s.ctl_lo[sfw_pkg::CL_MASTER];
    aud = s.ctl_hi[sfw_pkg::CH_AUDIO_EN];
    ign = s.ctl_hi[sfw_pkg::CH_IGN_UDR];
    framed = s.ctl_hi[sfw_pkg::CH_FRM_EN] | aud;
    sync_in = aud ? ~master : s.ctl_hi[sfw_pkg::CH_SYNC_DIR];
    pol = s.ctl_hi[sfw_pkg::CH_POL];
    fcnt = aud ? sfw_pkg::CNT_AUDIO
               : s.ctl_hi[sfw_pkg::CH_CNT_LO +: 3];
    fmask = framed ? frame_mask(fcnt) : 5'h00;
    pulse_word = s.ctl_hi[sfw_pkg::CH_PULSE_W]
               | (aud & (s.ctl_hi[sfw_pkg::CH_FMT_LO +: 2]
                         != sfw_pkg::FMT_PCM));
    len = word_len(aud, s.ctl_lo[sfw_pkg::CL_MODE32],
                   s.ctl_lo[sfw_pkg::CL_MODE16], s.wlen);
    cap = s.ctl_lo[sfw_pkg::CL_ENHBUF]
        ? fifo_depth(s.ctl_lo[sfw_pkg::CL_MODE32],
                     s.ctl_lo[sfw_pkg::CL_MODE16])
        : sfw_pkg::CAP_STD;
    len_mask = ~(32'hFFFFFFFF << len);

    // Polarity applied before edge finding, so either level works
    fs_edge = ((s.fs_sync[1] == pol) & (s.fs_prev != pol));
    div_hit = master & s.in_word & (s.div == 8'(SCK_HALF - 1));
    if (master) begin
      rise = div_hit & ~s.sck;
      fall = div_hit & s.sck;
    end else begin
      rise = s.sck_sync[1] & ~s.sck_prev;
      fall = ~s.sck_sync[1] & s.sck_prev;
    end

    repeat_word = aud & s.ctl_hi[sfw_pkg::CH_MONO] & s.word_idx[0];
    data_avail = s.sh_full | repeat_word;
    halted = ~ign & s.udr;
    if (framed & sync_in & (s.word_idx == 6'h00)) begin
      first_trig = fs_edge;
    end else begin
      first_trig = master ? data_avail : rise;
    end
    start = on & ~s.in_word & ~halted
          & ((master & (s.word_idx != 6'h00)) | first_trig);
    go = start & (data_avail | ign);

    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    shifter_idle = (s.tx_cnt == 6'h00) & ~s.sh_full;

    stat_lo = 16'h0000;
    stat_lo[sfw_pkg::ST_FRM_ERR] = s.frm_err;
    stat_lo[sfw_pkg::ST_BUSY] = s.in_word | ~shifter_idle;
    stat_lo[sfw_pkg::ST_UDR] = s.udr;
    stat_lo[sfw_pkg::ST_IDLE] = shifter_idle;
    stat_lo[sfw_pkg::ST_OVF] = s.ovf;
    stat_lo[sfw_pkg::ST_RBE] = (s.rx_cnt == 6'h00);
    stat_lo[sfw_pkg::ST_TBE] = (s.tx_cnt == 6'h00);
    stat_lo[sfw_pkg::ST_TBF] = (s.tx_cnt == cap);
    stat_lo[sfw_pkg::ST_RBF] = (s.rx_cnt == cap);

    if (wr_i) begin
      case (addr_i)
        sfw_pkg::REG_CTL_LO: begin
          n.ctl_lo = wdata_i & sfw_pkg::CL_MASK;
        end
        sfw_pkg::REG_CTL_HI: begin
          n.ctl_hi = wdata_i;
          if (on) begin
            n.ctl_hi[sfw_pkg::CH_AUDIO_EN] =
              s.ctl_hi[sfw_pkg::CH_AUDIO_EN];
            n.ctl_hi[sfw_pkg::CH_MONO] = s.ctl_hi[sfw_pkg::CH_MONO];
            n.ctl_hi[sfw_pkg::CH_FMT_LO +: 2] =
              s.ctl_hi[sfw_pkg::CH_FMT_LO +: 2];
          end
        end
        sfw_pkg::REG_WLEN: begin
          n.wlen = wdata_i[4:0];
        end
        sfw_pkg::REG_STAT_LO: begin
          if (!wdata_i[sfw_pkg::ST_FRM_ERR]) begin
            n.frm_err = 1'b0;
          end
          if (!wdata_i[sfw_pkg::ST_OVF]) begin
            n.ovf = 1'b0;
          end
        end
        sfw_pkg::REG_DATA_HI: begin
          n.stage_hi = wdata_i;
        end
        sfw_pkg::REG_DATA_LO: begin
          // Full buffer drops the write rather than stalling the bus
          if (on && s.tx_cnt != cap) begin
            tx_push = 1'b1;
            n.tx_mem[s.tx_wp] = {s.stage_hi, wdata_i};
            n.tx_wp = s.tx_wp + 5'h01;
          end
        end
        sfw_pkg::REG_URD_PAT: begin
          n.urd_pat = wdata_i;
        end
        default: begin
        end
      endcase
    end

    if (rd_i) begin
      case (addr_i)
        sfw_pkg::REG_CTL_LO:  n.rdata = s.ctl_lo;
        sfw_pkg::REG_CTL_HI:  n.rdata = s.ctl_hi;
        sfw_pkg::REG_WLEN:    n.rdata = {11'h000, s.wlen};
        sfw_pkg::REG_STAT_LO: n.rdata = stat_lo;
        sfw_pkg::REG_STAT_HI: n.rdata = {2'h0, s.rx_cnt, 2'h0, s.tx_cnt};
        sfw_pkg::REG_DATA_LO: begin
          n.rdata = s.rx_mem[s.rx_rp][15:0];
          if (s.rx_cnt != 6'h00) begin
            rx_pop = 1'b1;
            n.rx_rp = s.rx_rp + 5'h01;
          end
        end
        sfw_pkg::REG_DATA_HI: n.rdata = s.rx_mem[s.rx_rp][31:16];
        sfw_pkg::REG_URD_PAT: n.rdata = s.urd_pat;
        default:              n.rdata = 16'h0000;
      endcase
    end

    if (s.in_word) begin
      n.div = div_hit ? 8'h00 : s.div + 8'h01;
      n.sck = s.sck ^ div_hit;
    end else begin
      n.div = 8'h00;
      n.sck = 1'b0;
    end

    if (start) begin
      if (!data_avail) begin
        n.udr = 1'b1;
        n.tx_sh = (s.ctl_hi[sfw_pkg::CH_UDR_PAT]
                   ? {16'h0000, s.urd_pat} : s.last_rx)
                  << (6'h20 - len);
      end else begin
        if (ign) begin
          n.udr = 1'b0;
        end
        if (repeat_word) begin
          n.tx_sh = s.last_tx;
        end
      end
      if (go) begin
        n.in_word = 1'b1;
        n.sh_full = 1'b1;
      end
    end else if (on && !s.in_word && !s.sh_full && s.tx_cnt != 6'h00
                 && !repeat_word) begin
      tx_pop = 1'b1;
      n.tx_sh = s.tx_mem[s.tx_rp] << (6'h20 - len);
      n.last_tx = s.tx_mem[s.tx_rp] << (6'h20 - len);
      n.sh_full = 1'b1;
      n.tx_rp = s.tx_rp + 5'h01;
    end

    if ((s.in_word | go) & rise) begin
      n.rx_sh = {s.rx_sh[30:0], s.sdi_sync[1]};
      if (s.bit_cnt == len - 6'h01) begin
        n.tail = 1'b1;
        n.bit_cnt = 6'h00;
        rx_word = {s.rx_sh[30:0], s.sdi_sync[1]} & len_mask;
        n.last_rx = rx_word;
        if (s.rx_cnt == cap && !rx_pop) begin
          n.ovf = 1'b1;
        end else begin
          rx_push = 1'b1;
          n.rx_mem[s.rx_wp] = rx_word;
          n.rx_wp = s.rx_wp + 5'h01;
        end
      end else begin
        n.bit_cnt = s.bit_cnt + 6'h01;
      end
    end

    if (s.in_word && fall) begin
      if (s.tail) begin
        n.in_word = 1'b0;
        n.tail = 1'b0;
        n.sh_full = 1'b0;
        n.word_idx = (s.word_idx[4:0] == fmask) ? 6'h00
                   : s.word_idx + 6'h01;
      end else begin
        n.tx_sh = {s.tx_sh[30:0], 1'b0};
      end
    end

    // A sync edge inside a frame or word marks a misaligned frame
    if (on && framed && sync_in && fs_edge
        && (s.in_word || s.word_idx != 6'h00)) begin
      n.frm_err = 1'b1;
    end

    n.tx_cnt = s.tx_cnt + {5'h00, tx_push} - {5'h00, tx_pop};
    n.rx_cnt = s.rx_cnt + {5'h00, rx_push} - {5'h00, rx_pop};

    if (!on) begin
      n.tx_rp = 5'h00;
      n.tx_wp = 5'h00;
      n.rx_rp = 5'h00;
      n.rx_wp = 5'h00;
      n.tx_cnt = 6'h00;
      n.rx_cnt = 6'h00;
      n.sh_full = 1'b0;
      n.in_word = 1'b0;
      n.tail = 1'b0;
      n.bit_cnt = 6'h00;
      n.word_idx = 6'h00;
      // Park the clock at once so no stray edge follows switch-off
      n.sck = 1'b0;
      n.div = 8'h00;
      n.udr = 1'b0;
      n.frm_err = 1'b0;
      n.ovf = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    fs_assert = 1'b0;
    fs_oe_o = 1'b0;
    if (s.ctl_lo[sfw_pkg::CL_ON] && framed && !sync_in) begin
      fs_oe_o = 1'b1;
      fs_assert = s.in_word & (s.word_idx == 6'h00) & ~s.tail
                & (pulse_word | (s.bit_cnt == 6'h00));
    end else if (s.ctl_lo[sfw_pkg::CL_ON] && !framed && master
                 && s.ctl_hi[sfw_pkg::CH_SEL_DRV]) begin
      fs_oe_o = 1'b1;
      fs_assert = s.in_word;
    end
    fs_o = fs_oe_o & (fs_assert ? pol : ~pol);
  end

  assign rdata_o = s.rdata;
  assign sck_o = s.sck;
  assign sck_oe_o = s.ctl_lo[sfw_pkg::CL_ON] & s.ctl_lo[sfw_pkg::CL_MASTER];
  assign sdo_o = s.tx_sh[31];
  assign sdo_oe_o = s.ctl_lo[sfw_pkg::CL_ON];
endmodule // sfw_core
`default_nettype wire

//--- verilog/sfw_pkg.sv
// Behaviour
// - Frame sync direction 1 takes the sync pulse from outside; 0 drives it.
// - Frame polarity 1 makes sync and select active high, 0 active low.
// - Master select drive asserts the select pin during each master transfer when framing is off.
// - Pulse width 1 gives a one-word sync pulse, 0 one serial clock.
// - Frame word count gives one sync per 1, 2, 4, 8, 16 or 32 words.
// - Audio enable is writable only while the module is off.
// - Mono select is writable only while off and acts only in audio mode.
// - Underrun pattern enable matters only while ignore-underrun is set.
// - Audio format writable only while off; non-PCM formats force word pulse.
// - Word length code n gives n+1 bits; zero uses the fixed size.
// - Variable word length applies only with audio disabled.
// - FIFO depth follows the fixed size selection only.
// - Frame error flag set by hardware, held until software clears it.
// - Activity flag shows any transaction in progress, hardware only.
// - Underrun flag set when no data at word start, cleared when off.
// - With ignore-underrun the underrun flag is live and never halts.
// - Shifter idle flag is 1 only when buffer and shifter hold no data.
// - Overflow flag set when a word completes while receive buffer is full.
// - Receive empty flag means receive element count is zero.
// - Receive full flag means receive buffer holds its capacity.
// - Transmit empty flag means transmit element count is zero.
// - Transmit full flag means transmit buffer holds its capacity.
// - Audio mode forces framing, sync by role and count 001.
// - Without ignore-underrun an underrun stops serial operation.
`default_nettype none
package sfw_pkg;
  localparam logic [3:0] REG_CTL_LO  = 4'h0;
  localparam logic [3:0] REG_CTL_HI  = 4'h1;
  localparam logic [3:0] REG_WLEN    = 4'h2;
  localparam logic [3:0] REG_STAT_LO = 4'h3;
  localparam logic [3:0] REG_STAT_HI = 4'h4;
  localparam logic [3:0] REG_DATA_LO = 4'h5;
  localparam logic [3:0] REG_DATA_HI = 4'h6;
  localparam logic [3:0] REG_URD_PAT = 4'h7;

  localparam int CL_ON      = 15;
  localparam int CL_MODE32  = 11;
  localparam int CL_MODE16  = 10;
  localparam int CL_MASTER  = 5;
  localparam int CL_ENHBUF  = 0;
  localparam logic [15:0] CL_MASK = 16'h8C21;

  localparam int CH_AUDIO_EN = 15;
  localparam int CH_IGN_UDR  = 12;
  localparam int CH_MONO     = 11;
  localparam int CH_UDR_PAT  = 10;
  localparam int CH_FMT_LO   = 8;
  localparam int CH_FRM_EN   = 7;
  localparam int CH_SYNC_DIR = 6;
  localparam int CH_POL      = 5;
  localparam int CH_SEL_DRV  = 4;
  localparam int CH_PULSE_W  = 3;
  localparam int CH_CNT_LO   = 0;

  localparam int ST_FRM_ERR = 12;
  localparam int ST_BUSY    = 11;
  localparam int ST_UDR     = 8;
  localparam int ST_IDLE    = 7;
  localparam int ST_OVF     = 6;
  localparam int ST_RBE     = 5;
  localparam int ST_TBE     = 3;
  localparam int ST_TBF     = 1;
  localparam int ST_RBF     = 0;
  localparam int ST_RX_CNT  = 8;

  localparam logic [1:0] FMT_PCM   = 2'h3;
  localparam logic [2:0] CNT_AUDIO = 3'h1;

  localparam logic [5:0] LEN_8  = 6'h08;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_32 = 6'h20;

  localparam logic [5:0] DEPTH_W32 = 6'h08;
  localparam logic [5:0] DEPTH_W16 = 6'h10;
  localparam logic [5:0] DEPTH_W8  = 6'h20;
  localparam logic [5:0] CAP_STD   = 6'h01;
  localparam int         MEM_WORDS = 32;

  localparam int SCK_HALF_CYCLES = 4;
endpackage
`default_nettype wire

//--- bench/sfw_properties.sv
`default_nettype none
module sfw_properties #(
  parameter int SCK_HALF = 4
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        sck_i,
  input wire logic        sck_o,
  input wire logic        sck_oe_o,
  input wire logic        sdi_i,
  input wire logic        sdo_o,
  input wire logic        sdo_oe_o,
  input wire logic        fs_i,
  input wire logic        fs_o,
  input wire logic        fs_oe_o
);
  // Shadow of the controls, rebuilt from bus traffic alone
  typedef struct packed {
    logic        on;
    logic        mst;
    logic [15:0] hi;
    logic [4:0]  wl;
  } sfw_shadow_t;
  sfw_shadow_t sh;
  sfw_shadow_t next_sh;
  logic        frm_slv;
  logic        frm_mst;
  logic        sel_act;
  always_comb begin
    next_sh = sh;
    if (wr_i && addr_i == sfw_pkg::REG_CTL_LO) begin
      next_sh.on = wdata_i[sfw_pkg::CL_ON];
      next_sh.mst = wdata_i[sfw_pkg::CL_MASTER];
    end
    if (wr_i && addr_i == sfw_pkg::REG_CTL_HI) begin
      next_sh.hi = sh.on ? (sh.hi & 16'h8B00) | (wdata_i & 16'h74FF)
                         : wdata_i;
    end
    if (wr_i && addr_i == sfw_pkg::REG_WLEN) begin
      next_sh.wl = wdata_i[4:0];
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh <= '0;
    end else begin
      sh <= next_sh;
    end
  end
  assign frm_slv = sh.on && !sh.mst && sh.hi[7] && sh.hi[6] && !sh.hi[15];
  assign frm_mst = sh.on && sh.mst && sh.hi[7] && !sh.hi[6] && !sh.hi[15];
  // Select drive without framing holds the whole word; framed master with word pulse and count 0 drops it at the last rise
  assign sel_act = sh.on && sh.mst && !sh.hi[15]
    && ((sh.hi[4] && !sh.hi[7]) || (frm_mst && sh.hi[3] && sh.hi[2:0] == 3'h0));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RD_CTL_HI: assert property (rd_i && addr_i == sfw_pkg::REG_CTL_HI
    |=> rdata_o == $past(sh.hi)) else $error("control high readback wrong");
  AST_RD_WLEN: assert property (rd_i && addr_i == sfw_pkg::REG_WLEN
    |=> rdata_o == {11'h000, $past(sh.wl)}) else $error("word length wrong");
  AST_OFF_STATUS: assert property (rd_i && addr_i == sfw_pkg::REG_STAT_LO
    && !sh.on && !$past(sh.on) |=> (rdata_o & 16'h1B6B) == 16'h0028)
    else $error("status flags not cleared while off");
  AST_OFF_COUNTS: assert property (rd_i && addr_i == sfw_pkg::REG_STAT_HI
    && !sh.on && !$past(sh.on) |=> rdata_o == 16'h0000)
    else $error("element counts not zero while off");
  AST_SLAVE_FS_IN: assert property (frm_slv && $past(frm_slv)
    |-> !fs_oe_o) else $error("sync driven in input direction");
  AST_MASTER_FS_OUT: assert property (frm_mst && $past(frm_mst)
    |-> fs_oe_o) else $error("sync not driven in output direction");
  AST_SEL_ACTIVE: assert property ($rose(sck_o) && sel_act
    |-> fs_oe_o && fs_o == sh.hi[5]) else $error("select not active in word");
  AST_SCK_OFF: assert property (!sh.on && !$past(sh.on)
    |-> !sck_o && !sck_oe_o) else $error("serial clock active while off");
endmodule // sfw_properties
`default_nettype wire

//--- bench/sfw_peer.sv
`default_nettype none
module sfw_peer (
  input  wire logic mst_i,
  input  wire logic dut_sck_i,
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] tx_word = 32'h0;
  logic [31:0] rx_word = 32'h0;
  int          idx = 0;
  wire logic   sclk = mst_i ? dut_sck_i : sck_o;
  initial begin
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Mode 0: sample on rise, shift on fall
  always @(posedge sclk) begin
    rx_word = {rx_word[30:0], sdo_i};
  end
  always @(negedge sclk) begin
    if (idx > 0) begin
      idx = idx - 1;
      sdi_o = tx_word[idx];
    end else begin
      sdi_o = ~sdi_o; // No stale bit once hold time is over
    end
  end
  task automatic load(input logic [31:0] w, input int n);
    tx_word = w;
    idx = n - 1;
    sdi_o = w[n-1];
    rx_word = 32'h0;
  endtask
  // Clock runs only inside the word, off the system clock grid
  task automatic run_word(input int n);
    #13;
    for (int i = 0; i < n; i++) begin
      #100 sck_o = 1'b1;
      #100 sck_o = 1'b0;
    end
  endtask
endmodule // sfw_peer
`default_nettype wire

//--- bench/spi_framing_wordlen_status_tb_top.sv
`default_nettype none
module spi_framing_wordlen_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        mst = 1'b0;
  logic        fs = 1'b0;
  wire logic [15:0] rdata_o;
  wire logic   sck_o, sck_oe_o, sdo_o, sdo_oe_o, fs_o, fs_oe_o, sck_p, sdi_p;
  int          n_mismatch = 0;
  int          tests_run = 0;
  logic [15:0] v;
  logic [31:0] d;
  sfw_core i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sck_i(sck_p), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi_p),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .fs_i(fs), .fs_o(fs_o),
    .fs_oe_o(fs_oe_o));
  sfw_peer i_peer (.mst_i(mst), .dut_sck_i(sck_o), .sdo_i(sdo_o),
    .sck_o(sck_p), .sdi_o(sdi_p));
  always #12.5 clk_i = ~clk_i;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] dv);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= dv;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read strobe follows the write with no gap, catching the buffer load
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] dv,
                       input logic [3:0] ra);
    wr(a, dv);
    addr_i <= ra;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] dv);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    dv = rdata_o;
  endtask
  task automatic poll(input int b, input logic val);
    int k;
    k = 0;
    do begin
      rd(sfw_pkg::REG_STAT_LO, v);
      k++;
    end while (v[b] !== val && k < 400);
    chk(v[b], val);
  endtask
  function automatic int wlen(input logic [4:0] c, input logic [15:0] lo);
    if (c != 5'h00) return c + 1;
    return lo[11] ? 32 : (lo[10] ? 16 : 8);
  endfunction
  task automatic xfer(input logic [4:0] c, input logic [15:0] lo);
    int          n;
    logic [31:0] w;
    logic [31:0] m;
    logic [15:0] h;
    n = wlen(c, lo);
    m = (n == 32) ? 32'hFFFFFFFF : (32'h1 << n) - 32'h1;
    w = $urandom & m;
    mst = 1'b1;
    wr(sfw_pkg::REG_CTL_LO, 16'h0000);
    wr(sfw_pkg::REG_WLEN, {11'h000, c});
    wr(sfw_pkg::REG_CTL_HI, 16'h0030);
    wr(sfw_pkg::REG_CTL_LO, lo);
    i_peer.load(~w & m, n);
    wr(sfw_pkg::REG_DATA_HI, w[31:16]);
    wr_rd(sfw_pkg::REG_DATA_LO, w[15:0], sfw_pkg::REG_STAT_LO);
    chk({v[3], v[1]}, 2'b01);
    rd(sfw_pkg::REG_STAT_LO, v);
    chk({v[11], v[7]}, 2'b10);
    poll(7, 1'b1);
    chk(v[11], 1'b0);
    chk(i_peer.rx_word & m, w);
    chk({v[5], v[0]}, 2'b01);
    rd(sfw_pkg::REG_DATA_HI, h);
    rd(sfw_pkg::REG_DATA_LO, v);
    chk({h, v} & m, ~w & m);
    rd(sfw_pkg::REG_STAT_LO, v);
    chk({v[5], v[0]}, 2'b10);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    n_mismatch++;
    stop_test;
  end
  initial begin
    d = $urandom(32'h6C4E8D2A);
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(sfw_pkg::REG_STAT_LO, v);
    chk(v & 16'h1B6B, 16'h0028);
    rd(sfw_pkg::REG_STAT_HI, v);
    chk(v, 16'h0000);
    rd(4'hC, v);
    chk(v, 16'h0000);
    d = $urandom;
    wr(sfw_pkg::REG_CTL_HI, d[15:0]);
    rd(sfw_pkg::REG_CTL_HI, v);
    chk(v, d[15:0]);
    wr(sfw_pkg::REG_CTL_LO, 16'h8020);
    wr(sfw_pkg::REG_CTL_HI, d[31:16]);
    rd(sfw_pkg::REG_CTL_HI, v);
    chk(v, (d[15:0] & 16'h8B00) | (d[31:16] & 16'h74FF));
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      wr(sfw_pkg::REG_WLEN, d[15:0]);
      rd(sfw_pkg::REG_WLEN, v);
      chk(v, {11'h000, d[4:0]});
    end
    xfer(5'h01, 16'h8020);
    xfer(5'h0B, 16'h8020);
    xfer(5'h00, 16'h8420);
    xfer(5'h1F, 16'h8020);
    xfer(5'h00, 16'h8020);
    // Two words per frame with one word written: the second must underrun
    wr(sfw_pkg::REG_CTL_LO, 16'h0000);
    wr(sfw_pkg::REG_WLEN, 16'h0000);
    wr(sfw_pkg::REG_CTL_HI, 16'h0081);
    wr(sfw_pkg::REG_CTL_LO, 16'h8020);
    i_peer.load(32'h0, 8);
    wr(sfw_pkg::REG_DATA_LO, d[15:0]);
    poll(8, 1'b1);
    wr(sfw_pkg::REG_CTL_LO, 16'h0000);
    rd(sfw_pkg::REG_STAT_LO, v);
    chk(v[8], 1'b0);
    mst = 1'b0;
    d = $urandom;
    wr(sfw_pkg::REG_CTL_HI, 16'h1000);
    wr(sfw_pkg::REG_CTL_LO, 16'h8400);
    wr(sfw_pkg::REG_DATA_LO, d[15:0]);
    i_peer.load({16'h0000, d[31:16]}, 16);
    i_peer.run_word(16);
    poll(0, 1'b1);
    chk(i_peer.rx_word[15:0], d[15:0]);
    i_peer.load(~d, 16);
    i_peer.run_word(16);
    poll(6, 1'b1);
    rd(sfw_pkg::REG_DATA_LO, v);
    chk(v, d[31:16]);
    wr(sfw_pkg::REG_STAT_LO, 16'h0000);
    rd(sfw_pkg::REG_STAT_LO, v);
    chk(v[6], 1'b0);
    wr(sfw_pkg::REG_CTL_LO, 16'h0000);
    wr(sfw_pkg::REG_CTL_HI, 16'h00E0);
    wr(sfw_pkg::REG_CTL_LO, 16'h8000);
    // Framed slave: first sync edge starts a word, a second one inside errs
    wr(sfw_pkg::REG_DATA_LO, d[15:0]);
    @(posedge clk_i);
    fs <= 1'b1;
    repeat (6) @(posedge clk_i);
    fs <= 1'b0;
    rd(sfw_pkg::REG_STAT_LO, v);
    chk({v[12], v[11]}, 2'b01);
    repeat (4) @(posedge clk_i);
    fs <= 1'b1;
    poll(12, 1'b1);
    wr(sfw_pkg::REG_STAT_LO, 16'h0000);
    rd(sfw_pkg::REG_STAT_LO, v);
    chk(v[12], 1'b0);
    // Enhanced buffer: depth follows the fixed size, not the word length
    wr(sfw_pkg::REG_CTL_LO, 16'h0000);
    wr(sfw_pkg::REG_WLEN, 16'h0003);
    wr(sfw_pkg::REG_CTL_LO, 16'h8401);
    repeat (17) wr(sfw_pkg::REG_DATA_LO, d[15:0]);
    rd(sfw_pkg::REG_STAT_LO, v);
    chk({v[3], v[1]}, 2'b01);
    rd(sfw_pkg::REG_STAT_HI, v);
    chk(v, 16'h0010);
    repeat (4) @(posedge clk_i);
    stop_test;
  end
endmodule // spi_framing_wordlen_status_tb_top
bind sfw_core sfw_properties #(.SCK_HALF(SCK_HALF)) u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_i),
  .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi_i), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .fs_i(fs_i), .fs_o(fs_o), .fs_oe_o(fs_oe_o));
`default_nettype wire
